// ---- tb/brc_branch_ctrl_tb.sv ----
// self-checking bench for the branch control unit
// assumes one instruction in flight; bench drives ports 1 ns after each rising edge
`timescale 1ns/100ps
module brc_branch_ctrl_tb
  import brc_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce_in = 1'b1;
  logic carry_in = 1'b0;
  brc_instr_t instr = '0;
  brc_accus_t accumulator_operand = '0;
  logic busy;
  brc_result_t res;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  brc_branch_ctrl uut (
    .CLK_SYS_IN(clk_sys_in),
    .NRST_IN(nrst_in),
    .CE_IN(ce_in),
    .INSTR_IN(instr),
    .ACCUMULATOR_OPERAND_IN(accumulator_operand),
    .CARRY_IN(carry_in),
    .BUSY_OUT(busy),
    .RESULT_OUT(res)
  );

  // 50 MHz clock
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // present one instruction, count edges from accept to done, judge the result
  task automatic exec(input logic [7:0] op, a1, a2, input logic [12:0] pc, exp_pc,
                      input logic exp_load, exp_ill, input int n, gap);
    int k;
    instr = '{valid: 1'b1, opcode: op, arg1: a1, arg2: a2, pc: pc};
    @(posedge clk_sys_in);
    #1;
    instr.valid = 1'b0;
    k = 0;
    if (!exp_ill) chk("busy", busy, 1'b1);
    if (!exp_ill) chk("done_drop", res.done, 1'b0);
    if (gap > 0) begin
      ce_in = 1'b0; // frozen cycles must stretch the count one for one
      repeat (gap) @(posedge clk_sys_in);
      #1;
      ce_in = 1'b1;
      k = gap;
    end
    while (res.done !== 1'b1 && k < 12) begin
      @(posedge clk_sys_in);
      #1;
      k++;
    end
    chk("cycles", k[15:0], 16'(n - 1 + gap));
    chk("pc_load", res.pc_load, exp_load);
    chk("illegal", res.illegal, exp_ill);
    chk("next_pc", res.next_pc, exp_pc);
    chk("busy_end", busy, 1'b0);
  endtask

  task automatic t_jump();
    carry_in = 1'b1;
    exec(OP_JMP_REL, 8'h10, 8'h00, 13'h0100, 13'h0112, 1'b1, 1'b0, 3, 0);
    exec(OP_JMP_REL, 8'hf0, 8'h00, 13'h0001, 13'h1ff3, 1'b1, 1'b0, 3, 0);
    carry_in = 1'b0;
    exec(OP_JMP_ABS, 8'hff, 8'hab, 13'h0200, 13'h1fab, 1'b1, 1'b0, 4, 0);
  endtask

  task automatic t_carry();
    logic [7:0] op;
    logic tk;
    for (int c = 0; c < 2; c++) begin
      carry_in = c[0];
      for (int i = 0; i < 4; i++) begin
        op = OP_CARC_REL + 8'(i);
        tk = (i < 2) ? !carry_in : carry_in;
        if (i % 2 == 0) begin
          exec(op, 8'h20, 8'h00, 13'h0300, tk ? 13'h0322 : 13'h0302, tk, 1'b0, 3, 0);
        end else begin
          exec(op, 8'h05, 8'h5a, 13'h0300, tk ? 13'h055a : 13'h0303, tk, 1'b0, 4, 0);
        end
      end
    end
  endtask

  // wrong accumulator or wrong bit index shows as the opposite outcome
  task automatic t_bits();
    logic [23:0] m;
    logic [23:0] v4 [4];
    logic tk;
    for (int a = 0; a < 4; a++) begin
      for (int b = 0; b < 24; b += 23) begin
        for (int v = 0; v < 2; v++) begin
          for (int s = 0; s < 2; s++) begin
            m = 24'h1 << b;
            for (int i = 0; i < 4; i++) v4[i] = ((i == a) == (v == 1)) ? m : ~m;
            accumulator_operand = '{x: v4[0], y: v4[1], z: v4[2], r: v4[3]};
            tk = (s == 1) ? (v == 1) : (v == 0);
            exec((s == 1) ? (8'h4c + 8'(a)) : (8'h48 + 8'(a)), 8'(b), 8'h80, 13'h0400,
                 tk ? 13'h0383 : 13'h0403, tk, 1'b0, 4, 0);
          end
        end
      end
    end
  endtask

  task automatic t_illegal();
    exec(8'h48, 8'h18, 8'h00, 13'h0500, 13'h0501, 1'b0, 1'b1, 1, 0);
    exec(8'h46, 8'h00, 8'h00, 13'h1fff, 13'h0000, 1'b0, 1'b1, 1, 0);
    exec(OP_JMP_REL, 8'h7f, 8'h00, 13'h0000, 13'h0081, 1'b1, 1'b0, 3, 0);
  endtask

  task automatic t_ce();
    exec(OP_JMP_ABS, 8'h00, 8'h42, 13'h0600, 13'h0042, 1'b1, 1'b0, 4, 2);
  endtask

  // reset in mid-instruction must clear busy and the result at once
  task automatic t_reset();
    instr = '{valid: 1'b1, opcode: OP_JMP_ABS, arg1: 8'h01, arg2: 8'h00, pc: 13'h0000};
    @(posedge clk_sys_in);
    #1;
    instr.valid = 1'b0;
    nrst_in = 1'b0;
    #1;
    chk("rst_busy", busy, 1'b0);
    chk("rst_result", res.done | res.pc_load | res.illegal | (|res.next_pc), 1'b0);
    @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    t_jump();
    t_carry();
    t_bits();
    t_illegal();
    t_ce();
    t_reset();
    t_jump();
    give_verdict();
  end
endmodule

// ---- verilog/brc_branch_ctrl.sv ----
// branch control unit: decodes jump and branch instructions, times them,
// and hands the next program counter back to the core
// assumes the core holds the instruction and operands stable while valid is high
`timescale 1ns/100ps
module brc_branch_ctrl
  import brc_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire brc_instr_t INSTR_IN,
  input wire brc_accus_t ACCUMULATOR_OPERAND_IN,
  input wire logic CARRY_IN,
  output logic BUSY_OUT,
  output brc_result_t RESULT_OUT
);

  // address following an instruction of the given length
  function automatic logic [PC_W-1:0] seq_pc(input logic [PC_W-1:0] pc,
                                              input logic [1:0] len);
    seq_pc = pc + PC_W'(len);
  endfunction

  // relative target, signed offset counted from the following instruction
  function automatic logic [PC_W-1:0] rel_pc(input logic [PC_W-1:0] pc,
                                              input logic [1:0] len,
                                              input logic [7:0] off);
    rel_pc = seq_pc(pc, len) + {{(PC_W-8){off[7]}}, off};
  endfunction

  // accumulator selected by a two-bit operand
  function automatic logic [ACC_W-1:0] pick_acc(input brc_accus_t a,
                                                 input logic [1:0] sel);
    case (sel)
      2'h0: pick_acc = a.x;
      2'h1: pick_acc = a.y;
      2'h2: pick_acc = a.z;
      default: pick_acc = a.r;
    endcase
  endfunction

  brc_state_t state;
  logic [2:0] cnt;
  logic accept;
  brc_dec_t dec;
  logic [PC_W-1:0] abs_target;
  logic [ACC_W-1:0] sel_acc;
  logic sel_bit;
  logic taken_q;
  logic [PC_W-1:0] next_pc_q;

  // absolute target spans the full 13-bit program space
  assign abs_target = {INSTR_IN.arg1[4:0], INSTR_IN.arg2};
  // word picked first: a select straight on a call result is not portable
  assign sel_acc = pick_acc(ACCUMULATOR_OPERAND_IN, INSTR_IN.opcode[1:0]);
  assign sel_bit = sel_acc[INSTR_IN.arg1[4:0]];

  // decode: condition, cycle count and next address in one place
  always_comb begin
    dec.legal = 1'b1;
    dec.taken = 1'b0;
    dec.cyc = CYC_ILLEGAL;
    dec.next_pc = seq_pc(INSTR_IN.pc, LEN_ILLEGAL);
    case (INSTR_IN.opcode)
      OP_JMP_REL: begin
        dec.taken = 1'b1;
        dec.cyc = CYC_REL;
        dec.next_pc = rel_pc(INSTR_IN.pc, LEN_REL, INSTR_IN.arg1);
      end
      OP_JMP_ABS: begin
        dec.taken = 1'b1;
        dec.cyc = CYC_ABS;
        dec.next_pc = abs_target;
      end
      OP_CARC_REL, OP_CARS_REL: begin
        dec.taken = INSTR_IN.opcode[2] ? CARRY_IN : !CARRY_IN;
        dec.cyc = CYC_REL;
        dec.next_pc = dec.taken ? rel_pc(INSTR_IN.pc, LEN_REL, INSTR_IN.arg1)
                                : seq_pc(INSTR_IN.pc, LEN_REL);
      end
      OP_CARC_ABS, OP_CARS_ABS: begin
        dec.taken = INSTR_IN.opcode[2] ? CARRY_IN : !CARRY_IN;
        dec.cyc = CYC_ABS;
        dec.next_pc = dec.taken ? abs_target : seq_pc(INSTR_IN.pc, LEN_ABS);
      end
      default: begin
        if ((INSTR_IN.opcode[7:2] == OP_BITC_HI || INSTR_IN.opcode[7:2] == OP_BITS_HI)
            && INSTR_IN.arg1[4:0] <= BIT_MAX) begin
          // opcode bit 2 picks set-test over clear-test
          dec.taken = INSTR_IN.opcode[2] ? sel_bit : !sel_bit;
          dec.cyc = CYC_BIT;
          dec.next_pc = dec.taken ? rel_pc(INSTR_IN.pc, LEN_BIT, INSTR_IN.arg2)
                                  : seq_pc(INSTR_IN.pc, LEN_BIT);
        end else begin
          dec.legal = 1'b0;
        end
      end
    endcase
  end

  // a new instruction is taken only while idle and enabled
  assign accept = CE_IN && INSTR_IN.valid && state == ST_IDLE;
  assign BUSY_OUT = state == ST_EXEC;

  // sequencer: counts the remaining cycles of the running instruction
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
    end else if (CE_IN) begin
      unique case (state)
        ST_IDLE: begin
          if (accept && dec.legal) begin
            state <= ST_EXEC;
            cnt <= dec.cyc - 3'h1;
          end
        end
        ST_EXEC: begin
          cnt <= cnt - 3'h1;
          if (cnt == 3'h1) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // outcome is fixed at accept, so operands may change while executing
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      taken_q <= 1'b0;
      next_pc_q <= '0;
    end else if (CE_IN && accept) begin
      taken_q <= dec.taken;
      next_pc_q <= dec.next_pc;
    end
  end

  // result pulse; hands back the program counter with the pc_load and illegal flags
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RESULT_OUT <= '0;
    end else if (CE_IN) begin
      RESULT_OUT.done <= 1'b0;
      RESULT_OUT.pc_load <= 1'b0;
      RESULT_OUT.illegal <= 1'b0;
      if (accept && !dec.legal) begin
        // unknown code or bit index past 23: skip one byte, flag it
        RESULT_OUT.done <= 1'b1;
        RESULT_OUT.illegal <= 1'b1;
        RESULT_OUT.next_pc <= dec.next_pc;
      end else if (state == ST_EXEC && cnt == 3'h1) begin
        RESULT_OUT.done <= 1'b1;
        RESULT_OUT.pc_load <= taken_q;
        RESULT_OUT.next_pc <= next_pc_q;
      end
    end
  end

  property p_jmp_rel_time;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode == OP_JMP_REL) ##1 CE_IN [*2] |=>
      RESULT_OUT.done && RESULT_OUT.pc_load;
  endproperty
  a_jmp_rel_time: assert property (p_jmp_rel_time) else $error("relative jump not 3 cycles");

  property p_jmp_abs;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode == OP_JMP_ABS) ##1 CE_IN [*3] |=>
      RESULT_OUT.done && RESULT_OUT.pc_load && RESULT_OUT.next_pc == $past(abs_target, 4);
  endproperty
  a_jmp_abs: assert property (p_jmp_abs) else $error("absolute jump wrong target or time");

  property p_jmp_abs_early;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode == OP_JMP_ABS) ##1 CE_IN [*2] |=> !RESULT_OUT.done;
  endproperty
  a_jmp_abs_early: assert property (p_jmp_abs_early) else $error("absolute jump too short");

  property p_bitc;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode[7:2] == OP_BITC_HI && INSTR_IN.arg1[4:0] <= BIT_MAX)
      ##1 CE_IN [*3] |=> RESULT_OUT.done && RESULT_OUT.pc_load == !$past(sel_bit, 4);
  endproperty
  a_bitc: assert property (p_bitc) else $error("bit clear branch wrong decision");

  property p_bits;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode[7:2] == OP_BITS_HI && INSTR_IN.arg1[4:0] <= BIT_MAX)
      ##1 CE_IN [*3] |=> RESULT_OUT.done && RESULT_OUT.pc_load == $past(sel_bit, 4);
  endproperty
  a_bits: assert property (p_bits) else $error("bit set branch wrong decision");

  property p_bit_range;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode[7:3] == OP_BITC_HI[5:1] && INSTR_IN.arg1[4:0] > BIT_MAX)
      |=> RESULT_OUT.illegal && !BUSY_OUT;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit index above 23 accepted");

  property p_carc;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode == OP_CARC_REL) ##1 CE_IN [*2] |=>
      RESULT_OUT.done && RESULT_OUT.pc_load == !$past(CARRY_IN, 3);
  endproperty
  a_carc: assert property (p_carc) else $error("carry clear branch wrong decision");

  property p_cars;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode == OP_CARS_ABS) ##1 CE_IN [*3] |=>
      RESULT_OUT.done && RESULT_OUT.pc_load == $past(CARRY_IN, 4);
  endproperty
  a_cars: assert property (p_cars) else $error("carry set branch wrong decision");

  property p_rel_len;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode == OP_CARS_REL && !CARRY_IN) ##1 CE_IN [*2] |=>
      RESULT_OUT.next_pc == $past(INSTR_IN.pc, 3) + 13'h2;
  endproperty
  a_rel_len: assert property (p_rel_len) else $error("untaken relative branch length");

  property p_abs_fall;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (accept && INSTR_IN.opcode == OP_CARC_ABS && CARRY_IN) ##1 CE_IN [*3] |=>
      !RESULT_OUT.pc_load && RESULT_OUT.next_pc == $past(INSTR_IN.pc, 4) + 13'h3;
  endproperty
  a_abs_fall: assert property (p_abs_fall) else $error("untaken branch not sequential");

endmodule

// ---- verilog/brc_pkg.sv ----
// package for the branch control unit: widths, opcodes, lengths, cycle counts
// assumes the core presents one whole instruction (up to 3 bytes) at a time
package brc_pkg;

  localparam int PC_W = 13; // 8 kB of program bytes
  localparam int ACC_W = 24;
  localparam logic [4:0] BIT_MAX = 5'h17; // highest bit index, 23
  localparam logic [2:0] CNT_ZERO = 3'h0;

  // opcode byte values of each form
  localparam logic [7:0] OP_JMP_REL = 8'h40;
  localparam logic [7:0] OP_JMP_ABS = 8'h41;
  localparam logic [7:0] OP_CARC_REL = 8'h42;
  localparam logic [7:0] OP_CARC_ABS = 8'h43;
  localparam logic [7:0] OP_CARS_REL = 8'h44;
  localparam logic [7:0] OP_CARS_ABS = 8'h45;
  localparam logic [5:0] OP_BITC_HI = 6'h12; // 0x48..0x4b, low 2 bits = accumulator
  localparam logic [5:0] OP_BITS_HI = 6'h13; // 0x4c..0x4f, low 2 bits = accumulator

  // program bytes per form
  localparam logic [1:0] LEN_ILLEGAL = 2'h1;
  localparam logic [1:0] LEN_REL = 2'h2;
  localparam logic [1:0] LEN_ABS = 2'h3;
  localparam logic [1:0] LEN_BIT = 2'h3;

  // cycles per form
  localparam logic [2:0] CYC_ILLEGAL = 3'h1;
  localparam logic [2:0] CYC_REL = 3'h3;
  localparam logic [2:0] CYC_ABS = 3'h4;
  localparam logic [2:0] CYC_BIT = 3'h4;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [PC_W-1:0] pc; // address of the opcode byte
  } brc_instr_t;

  typedef struct packed {
    logic [ACC_W-1:0] x;
    logic [ACC_W-1:0] y;
    logic [ACC_W-1:0] z;
    logic [ACC_W-1:0] r;
  } brc_accus_t;

  typedef struct packed {
    logic done;
    logic pc_load;
    logic illegal;
    logic [PC_W-1:0] next_pc;
  } brc_result_t;

  typedef struct packed {
    logic legal;
    logic taken;
    logic [2:0] cyc;
    logic [PC_W-1:0] next_pc;
  } brc_dec_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } brc_state_t;

endpackage
